// *** rtl/move_rotate_return_exec.sv ***
// ============================================================
// executor for copy, idle, rotate and return instructions
// ============================================================
// assumes a classic wishbone master on the single clock clk_i
// How it works
// - copy reads file reg 0..127, writes accumulator if d=0, file if d=1
// - copy sets zero flag from the moved value
// - rotate left through carry; only carry flag changes
// - rotate left result to accumulator if d=0, file register if d=1
// - rotate right through carry; only carry flag changes
// - rotate right result to accumulator if d=0, file register if d=1
// - return with literal loads accumulator with literal, flags untouched
// - return with literal loads pc from stack head
// - return with literal takes two instruction cycles
// - every return pops the stack
module move_rotate_return_exec
  import exec_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             busy_o,
  output logic             irq_allow_o
);

  // ==========================================================
  // state
  // ==========================================================
  state_t            state_q;
  logic [13:0]       instr_q;
  logic [7:0]        acc_q, status_q;
  logic [PC_W-1:0]   pc_q;
  logic [PC_W-1:0]   stack_q [DEPTH];
  logic [SP_W-1:0]   sp_q;
  logic [6:0]        faddr_q;
  logic              ack_q, busy_q;
  logic [31:0]       dat_q;

  // bus decode
  logic              busy, req, wr, stall;
  assign busy  = (state_q != ST_IDLE);
  assign req   = wb_cyc_i && wb_stb_i;
  // writes wait until the executor is idle
  assign stall = wb_we_i && busy;
  // commit on the edge where the master sees ack
  assign wr    = req && wb_we_i && ack_q;

  // execute decode
  op_t               op;
  logic              exec, dest_file, f_we, is_ret, carry;
  logic [6:0]        f_addr, fw_addr;
  logic [7:0]        f_rd, rot_l, rot_r, result, fw_data;
  logic [PC_W-1:0]   head;

  assign op        = op_kind(instr_q);
  assign exec      = (state_q == ST_EXEC);
  assign dest_file = instr_q[DEST_BIT];
  assign f_addr    = exec ? instr_q[6:0] : faddr_q;
  assign carry     = status_q[CARRY_BIT];
  assign rot_l     = {f_rd[6:0], carry};
  assign rot_r     = {carry, f_rd[7:1]};
  assign head      = stack_q[sp_q];
  assign is_ret    = (op == OP_RETLIT) || (op == OP_RETIRQ);

  // result of file ops, plain copy otherwise
  assign result    = (op == OP_ROTL) ? rot_l : (op == OP_ROTR) ? rot_r : f_rd;

  // file write: executor first, bus only when idle
  logic file_op;
  assign file_op = (op == OP_COPY) || (op == OP_ROTL) || (op == OP_ROTR);
  always_comb
  begin
    f_we    = 1'b0;
    fw_addr = faddr_q;
    fw_data = wb_dat_i[7:0];
    if (exec && file_op && dest_file)
    begin
      f_we    = 1'b1;
      fw_addr = instr_q[6:0];
      fw_data = result;
    end
    else if (wr && wb_adr_i == REG_FILE_DATA && wb_sel_i[0])
      f_we = 1'b1;
  end

  file_reg_bank u_files (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .rd_addr_i (f_addr),
    .rd_data_o (f_rd),
    .wr_en_i   (f_we),
    .wr_addr_i (fw_addr),
    .wr_data_i (fw_data)
  );

  // sequencer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_q <= ST_IDLE;
    else
      case (state_q)
        ST_IDLE:  if (wr && wb_adr_i == REG_INSTR) state_q <= ST_EXEC;
        ST_EXEC:  state_q <= is_ret ? ST_FLUSH : ST_IDLE;
        ST_FLUSH: state_q <= ST_IDLE;
        default:  state_q <= ST_IDLE;
      endcase
  end

  // instruction latch
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      instr_q <= OPC_IDLE;
    else if (wr && wb_adr_i == REG_INSTR && !busy)
      instr_q <= wb_dat_i[13:0];
  end

  // ==========================================================
  // accumulator, flags, pc and stack
  // ==========================================================
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      acc_q <= ACC_RST;
    else if (exec && file_op && !dest_file)
      acc_q <= result;
    else if (exec && op == OP_RETLIT)
      acc_q <= instr_q[7:0];
    else if (wr && wb_adr_i == REG_ACC && wb_sel_i[0])
      acc_q <= wb_dat_i[7:0];
  end

  // status flags and irq allow
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      status_q <= STS_RST;
    else if (exec)
      case (op)
        OP_COPY:   status_q[ZERO_BIT]  <= (f_rd == 8'h00);
        OP_ROTL:   status_q[CARRY_BIT] <= f_rd[7];
        OP_ROTR:   status_q[CARRY_BIT] <= f_rd[0];
        OP_RETIRQ: status_q[IRQ_BIT]   <= 1'b1;
        default:   status_q <= status_q;
      endcase
    else if (wr && wb_adr_i == REG_STATUS && wb_sel_i[0])
      status_q <= wb_dat_i[7:0];
  end

  // program counter
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pc_q <= PC_RST;
    else if (exec && is_ret)
      pc_q <= head;
    else if (exec)
      pc_q <= pc_q + 13'h0001;
    else if (wr && wb_adr_i == REG_PC)
    begin
      if (wb_sel_i[0]) pc_q[7:0]  <= wb_dat_i[7:0];
      if (wb_sel_i[1]) pc_q[12:8] <= wb_dat_i[12:8];
    end
  end

  // return stack, circular, head at sp_q
  logic push;
  assign push = wr && wb_adr_i == REG_STACK && wb_sel_i[1:0] == 2'b11;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sp_q <= '0;
    else if (exec && is_ret)
      sp_q <= sp_q - 3'h1;
    else if (push)
      sp_q <= sp_q + 3'h1;
  end

  for (genvar i = 0; i < DEPTH; i++)
  begin : g_stack
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        stack_q[i] <= PC_RST;
      else if (push && sp_q + 3'h1 == 3'(i))
        stack_q[i] <= wb_dat_i[PC_W-1:0];
    end
  end

  // file pointer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      faddr_q <= 7'h00;
    else if (wr && wb_adr_i == REG_FILE_ADDR && wb_sel_i[0])
      faddr_q <= wb_dat_i[6:0];
  end

  // wishbone answer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_q <= 1'b0;
    else
      ack_q <= req && !ack_q && !stall;
  end

  // read data captured with ack, unmapped reads zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_q <= 32'h0000_0000;
    else if (req && !ack_q)
      case (wb_adr_i)
        REG_INSTR:     dat_q <= {31'h0, busy};
        REG_ACC:       dat_q <= {24'h0, acc_q};
        REG_STATUS:    dat_q <= {24'h0, status_q};
        REG_PC:        dat_q <= {19'h0, pc_q};
        REG_STACK:     dat_q <= {19'h0, head};
        REG_FILE_ADDR: dat_q <= {25'h0, faddr_q};
        REG_FILE_DATA: dat_q <= {24'h0, f_rd};
        REG_STACK_PTR: dat_q <= {29'h0, sp_q};
        default:       dat_q <= 32'h0000_0000;
      endcase
  end

  // busy follows the next state, so it stays high through the flush cycle of a return and drops as the state returns to idle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      busy_q <= 1'b0;
    else
      busy_q <= (state_q == ST_IDLE) ? (wr && wb_adr_i == REG_INSTR) : (exec && is_ret);
  end

  assign wb_ack_o    = ack_q;
  assign wb_dat_o    = dat_q;
  assign busy_o      = busy_q;
  assign irq_allow_o = status_q[IRQ_BIT];

  // ==========================================================
  // checks
  // ==========================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_flush_then_idle;
    state_q == ST_FLUSH && busy_o ##1 state_q == ST_IDLE && !busy_o;
  endsequence

  a_copy_dest: assert property (exec && op == OP_COPY |=>
    ($past(dest_file) ? acc_q == $past(acc_q) : acc_q == $past(f_rd)))
    else $error("copy destination wrong");
  a_copy_zero: assert property (exec && op == OP_COPY |=>
    status_q[ZERO_BIT] == ($past(f_rd) == 8'h00) && $stable(status_q[CARRY_BIT]))
    else $error("copy zero flag wrong");
  a_rotl_value: assert property (exec && op == OP_ROTL && !dest_file |=>
    acc_q == {$past(f_rd[6:0]), $past(carry)} && status_q[CARRY_BIT] == $past(f_rd[7])
    && $stable(status_q[ZERO_BIT])) else $error("rotate left wrong");
  a_rotl_file: assert property (exec && op == OP_ROTL && dest_file |=>
    u_files.mem_q[$past(instr_q[6:0])] == {$past(f_rd[6:0]), $past(carry)} && $stable(acc_q))
    else $error("rotate left write back wrong");
  a_rotr_value: assert property (exec && op == OP_ROTR && !dest_file |=>
    acc_q == {$past(carry), $past(f_rd[7:1])} && status_q[CARRY_BIT] == $past(f_rd[0])
    && $stable(status_q[ZERO_BIT])) else $error("rotate right wrong");
  a_rotr_file: assert property (exec && op == OP_ROTR && dest_file |=>
    u_files.mem_q[$past(instr_q[6:0])] == {$past(carry), $past(f_rd[7:1])} && $stable(acc_q))
    else $error("rotate right write back wrong");
  a_retlit_load: assert property (exec && op == OP_RETLIT |=>
    acc_q == $past(instr_q[7:0]) && $stable(status_q)) else $error("literal return load wrong");
  a_retlit_pc: assert property (exec && is_ret |=> pc_q == $past(head))
    else $error("return pc wrong");
  a_ret_cycles: assert property (exec && is_ret |=> s_flush_then_idle)
    else $error("return not two cycles");
  a_ret_pop: assert property (exec && is_ret |=> sp_q == $past(sp_q) - 3'h1)
    else $error("return did not pop");
  a_retirq_allow: assert property (exec && op == OP_RETIRQ |=>
    irq_allow_o && status_q[6:0] == $past(status_q[6:0])) else $error("irq return wrong");
  a_idle_only_pc: assert property (exec && op == OP_IDLE |=>
    $stable(acc_q) && $stable(status_q) && $stable(sp_q) && pc_q == $past(pc_q) + 13'h0001
    && state_q == ST_IDLE && !busy_o) else $error("idle changed state");

endmodule

// *** common/exec_pkg.sv ***
// ============================================================
// constants and types for the move, rotate and return executor
// ============================================================
// assumes a classic wishbone master with 32-bit data and byte addresses
package exec_pkg;

  // ==========================================================
  // register map, byte addresses on the wishbone
  // ==========================================================
  localparam logic [7:0] REG_INSTR     = 8'h00; // w: issue instruction, r: busy
  localparam logic [7:0] REG_ACC       = 8'h04; // accumulator
  localparam logic [7:0] REG_STATUS    = 8'h08; // flags and irq allow
  localparam logic [7:0] REG_PC        = 8'h0c; // program counter
  localparam logic [7:0] REG_STACK     = 8'h10; // w: push, r: stack head
  localparam logic [7:0] REG_FILE_ADDR = 8'h14; // file register pointer
  localparam logic [7:0] REG_FILE_DATA = 8'h18; // file register at pointer
  localparam logic [7:0] REG_STACK_PTR = 8'h1c; // r: stack pointer

  // ==========================================================
  // field positions
  // ==========================================================
  localparam int unsigned CARRY_BIT = 0;
  localparam int unsigned ZERO_BIT  = 2;
  localparam int unsigned IRQ_BIT   = 7;
  localparam int unsigned DEST_BIT  = 7;

  // ==========================================================
  // widths, depths and values after reset
  // ==========================================================
  localparam int unsigned PC_W    = 13;
  localparam int unsigned SP_W    = 3;
  localparam int unsigned DEPTH   = 8;
  localparam int unsigned FILES   = 128;
  localparam logic [7:0]  ACC_RST = 8'h00;
  localparam logic [7:0]  STS_RST = 8'h00;
  localparam logic [12:0] PC_RST  = 13'h0000;

  // ==========================================================
  // instruction encodings, 14-bit words
  // ==========================================================
  localparam logic [13:0] MASK_FD      = 14'h3f00; // file ops keep d,f free
  localparam logic [13:0] OPC_COPY     = 14'h0800;
  localparam logic [13:0] OPC_ROTL     = 14'h0d00;
  localparam logic [13:0] OPC_ROTR     = 14'h0c00;
  localparam logic [13:0] MASK_LIT     = 14'h3c00;
  localparam logic [13:0] OPC_RETLIT   = 14'h3400;
  localparam logic [13:0] OPC_RETIRQ   = 14'h0009;
  localparam logic [13:0] MASK_IDLE    = 14'h3f9f;
  localparam logic [13:0] OPC_IDLE     = 14'h0000;

  typedef enum logic [2:0] {
    OP_IDLE    = 3'b000,
    OP_COPY    = 3'b001,
    OP_ROTL    = 3'b010,
    OP_ROTR    = 3'b011,
    OP_RETLIT  = 3'b100,
    OP_RETIRQ  = 3'b101
  } op_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_EXEC  = 2'b01,
    ST_FLUSH = 2'b10
  } state_t;

  // instruction word to operation kind
  function automatic op_t op_kind(input logic [13:0] ins);
    op_t k;
    k = OP_IDLE;
    if ((ins & MASK_FD) == OPC_COPY)
      k = OP_COPY;
    else if ((ins & MASK_FD) == OPC_ROTL)
      k = OP_ROTL;
    else if ((ins & MASK_FD) == OPC_ROTR)
      k = OP_ROTR;
    else if ((ins & MASK_LIT) == OPC_RETLIT)
      k = OP_RETLIT;
    else if (ins == OPC_RETIRQ)
      k = OP_RETIRQ;
    return k;
  endfunction

endpackage

// *** rtl/file_reg_bank.sv ***
// ============================================================
// file register bank, 128 bytes of flip-flops
// ============================================================
// one combinational read port, one clocked write port
module file_reg_bank
  import exec_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [6:0] rd_addr_i,
  output logic      [7:0] rd_data_o,
  input  wire logic       wr_en_i,
  input  wire logic [6:0] wr_addr_i,
  input  wire logic [7:0] wr_data_i
);

  logic [7:0] mem_q [FILES];

  // read by index
  assign rd_data_o = mem_q[rd_addr_i];

  // one write process per byte
  for (genvar i = 0; i < FILES; i++)
  begin : g_byte
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        mem_q[i] <= 8'h00;
      else if (wr_en_i && wr_addr_i == 7'(i))
        mem_q[i] <= wr_data_i;
    end
  end

endmodule

// *** testbench/wb_host.sv ***
// ============================================================
// wishbone classic master standing in for the software side
// ============================================================
// assumes one clock; every request is launched after a rising edge
module wb_host
(
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [7:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // bus idle at time zero
  initial
  begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end

  // one classic cycle; ok stays low if no ack within the bound
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic ok);
    ok = 1'b0;
    q  = 32'h0;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    sel_o <= 4'hf;
    dat_o <= d;
    for (int n = 0; n < 50 && !ok; n++)
    begin
      @(posedge clk_i);
      if (ack_i === 1'b1)
      begin
        ok = 1'b1;
        q  = dat_i;
      end
    end
    // released data is scrambled so stale values never look valid
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o  <= 1'b0;
    dat_o <= ~d;
  endtask
endmodule

// *** testbench/tb.sv ***
// ============================================================
// self-checking bench for the move, rotate and return executor
// ============================================================
// assumes the register map and encodings of exec_pkg
module tb
  import exec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk_i;
  logic        rst_i;
  logic        cyc, stb, we, ack, busy_o, irq_allow_o;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat;
  int          errors;
  int          num_checks;

  // 50 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  move_rotate_return_exec uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .busy_o(busy_o), .irq_allow_o(irq_allow_o));

  wb_host host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

  // ==========================================================
  // shared tasks
  // ==========================================================
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    logic ok;
    host.xfer(w, a, d, q, ok);
    if (!ok)
    begin
      errors++;
      $display("Error at %0t: no ack", $time);
      end_of_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp, what);
  endtask

  task automatic set_file(input logic [7:0] a, input logic [7:0] d);
    wr(REG_FILE_ADDR, {24'h0, a});
    wr(REG_FILE_DATA, {24'h0, d});
  endtask

  // issue one instruction and count the cycles busy stays high
  task automatic exec(input logic [13:0] ins, input int cycles);
    int n;
    n = 0;
    wr(REG_INSTR, {18'h0, ins});
    @(negedge clk_i);
    while (busy_o === 1'b1 && n < 20)
    begin
      n++;
      @(negedge clk_i);
    end
    if (n >= 20)
    begin
      errors++;
      $display("Error at %0t: busy stuck", $time);
      end_of_test();
    end
    chk(32'(n), 32'(cycles), "instruction cycles");
  endtask

  // ==========================================================
  // scenarios
  // ==========================================================
  task automatic t_reset();
    rd_chk(REG_ACC, 32'h0, "acc reset");
    rd_chk(REG_STATUS, 32'h0, "status reset");
    rd_chk(REG_PC, 32'h0, "pc reset");
    wr(8'h20, 32'hffff);
    rd_chk(8'h20, 32'h0, "unmapped read");
    chk({31'h0, irq_allow_o}, 32'h0, "irq allow reset");
  endtask

  task automatic t_copy();
    wr(REG_ACC, 32'h33);
    set_file(8'h7f, 8'h00);
    wr(REG_STATUS, 32'h0);
    exec(OPC_COPY | 14'h007f, 1);
    rd_chk(REG_ACC, 32'h00, "copy to acc");
    rd_chk(REG_STATUS, 32'h04, "copy zero set");
    set_file(8'h05, 8'h5a);
    exec(OPC_COPY | 14'h0085, 1);
    rd_chk(REG_FILE_DATA, 32'h5a, "copy to self");
    rd_chk(REG_ACC, 32'h00, "copy acc kept");
    rd_chk(REG_STATUS, 32'h00, "copy zero clear");
  endtask

  task automatic t_rotl();
    set_file(8'h03, 8'h81);
    wr(REG_STATUS, 32'h04);
    exec(OPC_ROTL | 14'h0083, 1);
    rd_chk(REG_FILE_DATA, 32'h02, "rotl file");
    rd_chk(REG_STATUS, 32'h05, "rotl carry out");
    exec(OPC_ROTL | 14'h0003, 1);
    rd_chk(REG_ACC, 32'h05, "rotl acc");
    rd_chk(REG_FILE_DATA, 32'h02, "rotl file kept");
    rd_chk(REG_STATUS, 32'h04, "rotl carry clear");
  endtask

  task automatic t_rotr();
    set_file(8'h03, 8'h02);
    wr(REG_STATUS, 32'h05);
    exec(OPC_ROTR | 14'h0083, 1);
    rd_chk(REG_FILE_DATA, 32'h81, "rotr file");
    rd_chk(REG_STATUS, 32'h04, "rotr carry out");
    exec(OPC_ROTR | 14'h0003, 1);
    rd_chk(REG_ACC, 32'h40, "rotr acc");
    rd_chk(REG_FILE_DATA, 32'h81, "rotr file kept");
    rd_chk(REG_STATUS, 32'h05, "rotr carry set");
  endtask

  task automatic t_retlit();
    wr(REG_STACK, 32'h0123);
    wr(REG_STACK, 32'h0456);
    wr(REG_STATUS, 32'h05);
    exec(OPC_RETLIT | 14'h00ff, 2);
    rd_chk(REG_ACC, 32'hff, "literal to acc");
    rd_chk(REG_STATUS, 32'h05, "literal flags kept");
    rd_chk(REG_PC, 32'h0456, "literal pc");
    rd_chk(REG_STACK, 32'h0123, "literal pop head");
    rd_chk(REG_STACK_PTR, 32'h1, "literal pop ptr");
    // an instruction written during a return is held off, then runs
    wr(REG_INSTR, {18'h0, OPC_RETLIT | 14'h00ff});
    wr(REG_INSTR, {18'h0, OPC_IDLE});
    repeat (3) @(posedge clk_i);
    rd_chk(REG_PC, 32'h0124, "held idle ran");
    rd_chk(REG_STACK_PTR, 32'h0, "held return pop");
    wr(REG_STACK, 32'h0123);
  endtask

  task automatic t_retirq();
    exec(OPC_RETIRQ, 2);
    rd_chk(REG_PC, 32'h0123, "irq return pc");
    rd_chk(REG_STATUS, 32'h85, "irq return flags");
    chk({31'h0, irq_allow_o}, 32'h1, "irq allow set");
    rd_chk(REG_STACK_PTR, 32'h0, "irq return pop");
  endtask

  task automatic t_idle();
    exec(OPC_IDLE, 1);
    rd_chk(REG_PC, 32'h0124, "idle pc step");
    rd_chk(REG_ACC, 32'hff, "idle acc kept");
    rd_chk(REG_STATUS, 32'h85, "idle flags kept");
    rd_chk(REG_STACK_PTR, 32'h0, "idle stack kept");
  endtask

  // ==========================================================
  // main sequence
  // ==========================================================
  initial
  begin
    errors     = 0;
    num_checks = 0;
    rst_i      = 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_copy();
    t_rotl();
    t_rotr();
    t_retlit();
    t_retirq();
    t_idle();
    end_of_test();
  end
endmodule
